// file: hw/eer_pkg.sv
// constants for the identification data emulation router
// assumes one 20 MHz clock; sizes and timing shared by both design files
package eer_pkg;
	localparam int          CLK_HZ         = 20000000;
	localparam int          HPD_TOGGLE_SEC = 2;
	localparam int          HPD_CYCLES     = CLK_HZ * HPD_TOGGLE_SEC;
	localparam int          BLOCK_BYTES    = 128;
	localparam int          IMAGE_BYTES    = 2 * BLOCK_BYTES;
	localparam logic [8:0]  BASE_LAST      = 9'h07f;
	localparam logic [8:0]  EXT_LAST       = 9'h0ff;
	localparam logic [0:0]  MODE_STATIC    = 1'h0;
	localparam logic [0:0]  MODE_DYNAMIC   = 1'h1;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;
	typedef enum logic [1:0] {EER_IDLE, EER_COPY, EER_HPD} eer_port_state_t;
endpackage

// file: hw/eer_input_port.sv
// one input's own image store, read port and hot-plug sequencer
// assumes the router feeds it an image stream one byte per strobe
`timescale 1ns/100ps
module eer_input_port
#(
	parameter int HPD_CYC = eer_pkg::HPD_CYCLES
)
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       load_start,
	input  wire logic       load_we,
	input  wire logic [7:0] load_addr,
	input  wire logic [7:0] load_data,
	input  wire logic       load_ext,
	input  wire logic       load_done,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	output logic            has_ext,
	output logic            hpd,
	output logic            busy
);
	import eer_pkg::*;

	// ==========================================
	// image store, private to this input
	logic [7:0]      mem [IMAGE_BYTES];
	logic [31:0]     hpd_cnt;
	eer_port_state_t state;
	wire             hpd_end = (hpd_cnt == 32'(HPD_CYC - 1));

	always_ff @(posedge ref_clk)
	begin
		if (load_we)
			mem[load_addr] <= load_data;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rd_data <= RESET_BYTE;
		else
			rd_data <= mem[rd_addr];
	end

	// ==========================================
	// hot-plug low while the image changes, then a full toggle time
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state   <= EER_IDLE;
			hpd_cnt <= '0;
			hpd     <= 1'b1;
			busy    <= 1'b0;
			has_ext <= 1'b0;
		end
		else
		begin
			case (state)
				EER_IDLE:
				begin
					if (load_start)
					begin
						state <= EER_COPY;
						hpd   <= 1'b0;
						busy  <= 1'b1;
					end
				end
				EER_COPY:
				begin
					if (load_done)
					begin
						state   <= EER_HPD;
						has_ext <= load_ext;
						hpd_cnt <= '0;
					end
				end
				EER_HPD:
				begin
					hpd_cnt <= hpd_cnt + 32'h1;
					if (hpd_end)
					begin
						state <= EER_IDLE;
						hpd   <= 1'b1;
						busy  <= 1'b0;
					end
				end
				default:
					state <= EER_IDLE;
			endcase
		end
	end
endmodule

// file: hw/eer_router.sv
// identification data emulation router: per-output sink copies, per-input emulation
// assumes sink images arrive byte-wise with a validity flag from the output side,
// and the source reads each input's image by byte address over its own channel
// Overview of operation
// - each output keeps a retained copy of its sink's image, kept after unplug
// - any input shows a stored image or the last sink image of any output
// - dynamic inputs follow a replaced sink automatically when its data is valid
// - each input has its own store; loading one leaves others untouched
// - a presented image change drops hot-plug for two seconds
// - changes are taken while a source stays connected and powered
// - image is a 128-byte base block plus optional 128-byte extension
`timescale 1ns/100ps
module eer_router
#(
	parameter int N_IN    = 2,
	parameter int N_OUT   = 2,
	parameter int N_STORE = 4,
	parameter int HPD_CYC = eer_pkg::HPD_CYCLES
)
(
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	// sink image capture, one output at a time
	input  wire logic                       snk_we,
	input  wire logic [$clog2(N_OUT)-1:0]   snk_sel,
	input  wire logic [7:0]                 snk_addr,
	input  wire logic [7:0]                 snk_data,
	input  wire logic                       snk_done,
	input  wire logic                       snk_valid,
	input  wire logic                       snk_ext,
	// static store programming
	input  wire logic                       sto_we,
	input  wire logic [$clog2(N_STORE)-1:0] sto_sel,
	input  wire logic [7:0]                 sto_addr,
	input  wire logic [7:0]                 sto_data,
	input  wire logic                       sto_ext,
	// emulation selection
	input  wire logic                       cfg_we,
	input  wire logic [$clog2(N_IN)-1:0]    cfg_in,
	input  wire logic [0:0]                 cfg_mode,
	input  wire logic [7:0]                 cfg_src,
	// source reads and hot-plug, plus sink copy status
	input  wire logic [N_IN*8-1:0]          ddc_addr,
	output logic      [N_IN*8-1:0]          ddc_data,
	output logic      [N_IN-1:0]            ddc_has_ext,
	output logic      [N_IN-1:0]            hpd,
	output logic                            copy_busy
);
	import eer_pkg::*;

	localparam int N_IMG = N_STORE + N_OUT;

	// ==========================================
	// image memories: static slots then per-output sink copies
	// the sink copy only becomes current on a valid completed capture, so a
	// bad read never overwrites the last good image
	logic [7:0] img    [N_IMG][IMAGE_BYTES];
	logic [7:0] shadow [N_OUT][IMAGE_BYTES];
	logic       img_ext [N_IMG];
	logic       out_ok  [N_OUT];
	logic [N_OUT-1:0] out_new;
	logic                     copy_we_out;
	logic [$clog2(N_OUT)-1:0] cp_out;
	logic [7:0]               cp_addr;
	logic                     cp_active;

	always_ff @(posedge ref_clk)
	begin
		if (snk_we)
			shadow[snk_sel][snk_addr] <= snk_data;
		if (sto_we)
			img[sto_sel][sto_addr] <= sto_data;
		if (copy_we_out)
			img[N_STORE + int'(cp_out)][cp_addr] <= shadow[cp_out][cp_addr];
	end

	// ==========================================
	// sink capture commit
	wire snk_commit = snk_done & snk_valid;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cp_active <= 1'b0;
			cp_out    <= '0;
			cp_addr   <= 8'h00;
		end
		else if (!cp_active && snk_commit)
		begin
			cp_active <= 1'b1;
			cp_out    <= snk_sel;
			cp_addr   <= 8'h00;
		end
		else if (cp_active)
		begin
			cp_addr <= cp_addr + 8'h01;
			if (cp_addr == EXT_LAST[7:0])
				cp_active <= 1'b0;
		end
	end
	assign copy_we_out = cp_active;
	wire cp_finish = cp_active & (cp_addr == EXT_LAST[7:0]);

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			copy_busy <= 1'b0;
			out_new   <= '0;
			for (int o = 0; o < N_OUT; o++)
				out_ok[o] <= 1'b0;
			for (int s = 0; s < N_IMG; s++)
				img_ext[s] <= 1'b0;
		end
		else
		begin
			copy_busy <= cp_active | (!cp_active & snk_commit);
			out_new   <= '0;
			if (sto_we)
				img_ext[sto_sel] <= sto_ext;
			if (!cp_active && snk_commit)
				img_ext[N_STORE + int'(snk_sel)] <= snk_ext;
			if (cp_finish)
			begin
				out_ok[cp_out]  <= 1'b1;
				out_new[cp_out] <= 1'b1;
			end
		end
	end

	// ==========================================
	// per-input emulation selection and image load
	// each input keeps its selection locally, so every register has one writer
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi++)
		begin : g_in
			logic [7:0] ld_addr;
			logic       ld_run;
			logic       ld_pend;
			logic       ld_start;
			logic       p_busy;
			logic [0:0] in_mode;
			logic [7:0] in_src;
			wire  [7:0] slot     = (in_mode == MODE_DYNAMIC) ?
				8'(N_STORE) + in_src : in_src;
			wire        slot_ok  = (int'(slot) < N_IMG) &&
				((in_mode == MODE_STATIC) || out_ok[int'(in_src) % N_OUT]);
			wire        cfg_hit  = cfg_we && (int'(cfg_in) == gi);
			wire        follow   = (in_mode == MODE_DYNAMIC) &&
				(int'(in_src) < N_OUT) && out_new[int'(in_src) % N_OUT];
			wire  [7:0] ld_data  = img[int'(slot) % N_IMG][ld_addr];
			wire        ld_last  = ld_addr == EXT_LAST[7:0];

			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
				begin
					in_mode     <= MODE_STATIC;
					in_src      <= 8'h00;
					ld_pend     <= 1'b1;
					ld_run      <= 1'b0;
					ld_start    <= 1'b0;
					ld_addr     <= 8'h00;
				end
				else
				begin
					ld_start <= 1'b0;
					if (cfg_hit)
					begin
						// source may stay attached; no cable event is needed
						in_mode <= cfg_mode;
						in_src  <= cfg_src;
					end
					if (cfg_hit || follow)
						ld_pend <= 1'b1;
					else if (ld_pend && !ld_run && !p_busy && slot_ok)
					begin
						ld_pend  <= 1'b0;
						ld_run   <= 1'b1;
						ld_start <= 1'b1;
						ld_addr  <= 8'h00;
					end
					else if (ld_pend && !slot_ok && !ld_run)
						ld_pend <= 1'b0;
					if (ld_run)
					begin
						ld_addr <= ld_addr + 8'h01;
						if (ld_last)
							ld_run <= 1'b0;
					end
				end
			end

			eer_input_port #(
				.HPD_CYC (HPD_CYC)
			) u_port (
				.ref_clk    (ref_clk),
				.rstn       (rstn),
				.load_start (ld_start),
				.load_we    (ld_run),
				.load_addr  (ld_addr),
				.load_data  (ld_data),
				.load_ext   (img_ext[int'(slot) % N_IMG]),
				.load_done  (ld_run & ld_last),
				.rd_addr    (ddc_addr[gi*8 +: 8]),
				.rd_data    (ddc_data[gi*8 +: 8]),
				.has_ext    (ddc_has_ext[gi]),
				.hpd        (hpd[gi]),
				.busy       (p_busy)
			);
		end
	endgenerate
endmodule

// file: verif/eer_router_assertions.sv
// checker on the router's top ports
// assumes one clock and the bench's short hot-plug count
`timescale 1ns/100ps
module eer_router_assertions
	import eer_pkg::*;
#(
	parameter int N_IN    = 2,
	parameter int HPD_CYC = 50
)
(
	input wire logic                    ref_clk,
	input wire logic                    rstn,
	input wire logic                    snk_done,
	input wire logic                    snk_valid,
	input wire logic                    cfg_we,
	input wire logic [$clog2(N_IN)-1:0] cfg_in,
	input wire logic [0:0]              cfg_mode,
	input wire logic [N_IN*8-1:0]       ddc_addr,
	input wire logic [N_IN*8-1:0]       ddc_data,
	input wire logic [N_IN-1:0]         ddc_has_ext,
	input wire logic [N_IN-1:0]         hpd,
	input wire logic                    copy_busy
);
	int low_cnt;
	int busy_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// =====================
	// span counters
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_cnt  <= 0;
			busy_cnt <= 0;
		end
		else
		begin
			low_cnt  <= hpd[0] ? 0 : low_cnt + 1;
			busy_cnt <= copy_busy ? busy_cnt + 1 : 0;
		end
	end
	// =====================
	// properties
	property p_cfg_hpd;
		cfg_we && cfg_in == 0 && cfg_mode == MODE_STATIC && hpd[0] |-> ##[1:4] !hpd[0];
	endproperty
	a_cfg_hpd: assert property (p_cfg_hpd) else $error("no hot-plug drop");
	property p_hpd_len;
		$rose(hpd[0]) |-> low_cnt >= 255 + HPD_CYC;
	endproperty
	a_hpd_len: assert property (p_hpd_len) else $error("hot-plug drop short");
	property p_ext_hold;
		hpd[0] && $past(hpd[0]) |-> $stable(ddc_has_ext[0]);
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("extension flag moved");
	property p_data_hold;
		hpd[0] && $past(hpd[0]) && $stable(ddc_addr[7:0]) |=> $stable(ddc_data[7:0]);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("image moved");
	property p_other_hold;
		!hpd[0] && hpd[1] && $past(hpd[1]) && $stable(ddc_addr[15:8])
			|=> $stable(ddc_data[15:8]);
	endproperty
	a_other_hold: assert property (p_other_hold) else $error("other input moved");
	property p_bad_sink;
		snk_done && !snk_valid && !copy_busy |=> !copy_busy [*4];
	endproperty
	a_bad_sink: assert property (p_bad_sink) else $error("bad sink taken");
	property p_commit;
		snk_done && snk_valid && !copy_busy |-> ##[1:3] copy_busy;
	endproperty
	a_commit: assert property (p_commit) else $error("commit missing");
	property p_copy_len;
		$fell(copy_busy) |-> busy_cnt >= 255 && busy_cnt <= 257;
	endproperty
	a_copy_len: assert property (p_copy_len) else $error("copy length");
endmodule

// file: verif/eer_src_model.sv
// video source: rereads the whole image after each hot-plug rise
// assumes registered read data one cycle after the address
`timescale 1ns/100ps
module eer_src_model
(
	input  wire logic       ref_clk,
	input  wire logic       hpd,
	input  wire logic [7:0] ddc_data,
	output logic      [7:0] ddc_addr = 8'h00,
	output logic            idle
);
	logic [7:0] mem [256];
	logic       hpd_q = 1'b1;
	int         n = 300;
	assign idle = n > 256;
	// a drop mid-read abandons it, as a real source does
	always @(posedge ref_clk)
	begin
		hpd_q <= hpd;
		if (!hpd)
			n <= 300;
		else if (!hpd_q)
			n <= 0;
		else if (n < 257)
			n <= n + 1;
		if (n >= 1 && n < 257)
			mem[n-1] <= ddc_data;
		ddc_addr <= (hpd && !hpd_q) ? 8'h00 : 8'(n + 1);
	end
endmodule

// file: verif/eer_router_tb_top.sv
// self-checking bench for the emulation router
// assumes a shortened hot-plug count of 50 cycles
`timescale 1ns/100ps
module eer_router_tb_top;
	import eer_pkg::*;
	logic       ref_clk = 1'b0, rstn = 1'b0, snk_we = 1'b0, snk_done = 1'b0;
	logic       snk_valid = 1'b0, snk_ext = 1'b0, sto_we = 1'b0, sto_ext = 1'b0;
	logic       cfg_we = 1'b0, copy_busy;
	logic [0:0] snk_sel = 1'h1, cfg_in = 1'h0, cfg_mode = 1'h0;
	logic [1:0] sto_sel = 2'h1, ddc_has_ext, hpd;
	logic [7:0] snk_addr = 8'h00, snk_data = 8'h00, sto_addr = 8'h00;
	logic [7:0] sto_data = 8'h00, cfg_src = 8'h00;
	logic [15:0] ddc_data;
	wire [15:0] ddc_addr;
	wire [1:0]  idle;
	int         fails = 0;
	int         n_tests = 0;
	always #25 ref_clk = ~ref_clk;
	eer_router #(.HPD_CYC(50)) dut_u (
		.ref_clk     (ref_clk),
		.rstn        (rstn),
		.snk_we      (snk_we),
		.snk_sel     (snk_sel),
		.snk_addr    (snk_addr),
		.snk_data    (snk_data),
		.snk_done    (snk_done),
		.snk_valid   (snk_valid),
		.snk_ext     (snk_ext),
		.sto_we      (sto_we),
		.sto_sel     (sto_sel),
		.sto_addr    (sto_addr),
		.sto_data    (sto_data),
		.sto_ext     (sto_ext),
		.cfg_we      (cfg_we),
		.cfg_in      (cfg_in),
		.cfg_mode    (cfg_mode),
		.cfg_src     (cfg_src),
		.ddc_addr    (ddc_addr),
		.ddc_data    (ddc_data),
		.ddc_has_ext (ddc_has_ext),
		.hpd         (hpd),
		.copy_busy   (copy_busy)
	);
	eer_src_model m0 (.ref_clk(ref_clk), .hpd(hpd[0]), .ddc_data(ddc_data[7:0]),
		.ddc_addr(ddc_addr[7:0]), .idle(idle[0]));
	eer_src_model m1 (.ref_clk(ref_clk), .hpd(hpd[1]), .ddc_data(ddc_data[15:8]),
		.ddc_addr(ddc_addr[15:8]), .idle(idle[1]));
	// =====================
	// shared tasks
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
		#5;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fill(input logic st, input logic [7:0] s);
		for (int a = 0; a < 256; a++)
		begin
			{sto_we, snk_we} = {st, !st};
			{sto_addr, snk_addr} = {2{a[7:0]}};
			{sto_data, snk_data} = {2{s ^ a[7:0]}};
			cyc(1);
		end
		{sto_we, snk_we} = 2'b00;
	endtask
	task automatic commit(input logic v, input logic x);
		{snk_done, snk_valid, snk_ext} = {1'b1, v, x};
		cyc(1);
		snk_done = 1'b0;
		cyc(3);
		chk({7'h00, copy_busy}, {7'h00, v});
		for (int k = 0; copy_busy && k < 400; k++)
			cyc(1);
		chk({7'h00, copy_busy}, 8'h00);
	endtask
	task automatic sel(input logic [0:0] i, input logic [0:0] md, input logic [7:0] src);
		{cfg_we, cfg_in, cfg_mode, cfg_src} = {1'b1, i, md, src};
		cyc(1);
		cfg_we = 1'b0;
	endtask
	// the source's copy is judged only after its full reread
	task automatic look(input int i, input logic [7:0] s, input logic x);
		int k;
		for (k = 0; hpd[i] && k < 400; k++)
			cyc(1);
		chk({7'h00, hpd[i]}, 8'h00);
		for (k = 0; !hpd[i] && k < 1000; k++)
			cyc(1);
		chk({7'h00, hpd[i]}, 8'h01);
		cyc(2);
		for (k = 0; !idle[i] && k < 300; k++)
			cyc(1);
		chk({7'h00, idle[i]}, 8'h01);
		chk({7'h00, ddc_has_ext[i]}, {7'h00, x});
		for (k = 0; k < (x ? IMAGE_BYTES : BLOCK_BYTES); k++)
			chk(i ? m1.mem[k] : m0.mem[k], s ^ k[7:0]);
	endtask
	// =====================
	// scenarios
	task automatic t_static;
		sto_ext = 1'b1;
		fill(1'b1, 8'h5a);
		sel(1'h0, MODE_STATIC, 8'h01);
		look(0, 8'h5a, 1'b1);
		chk({7'h00, hpd[1]}, 8'h01);
	endtask
	task automatic t_dynamic;
		fill(1'b0, 8'h3c);
		commit(1'b1, 1'b0);
		sel(1'h1, MODE_DYNAMIC, 8'h01);
		look(1, 8'h3c, 1'b0);
		fill(1'b0, 8'hc3);
		commit(1'b0, 1'b1);
		cyc(400);
		chk({7'h00, hpd[1]}, 8'h01);
		fill(1'b0, 8'h96);
		commit(1'b1, 1'b1);
		look(1, 8'h96, 1'b1);
	endtask
	task automatic t_retain;
		sel(1'h0, MODE_DYNAMIC, 8'h01);
		look(0, 8'h96, 1'b1);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		cyc(12);
		rstn = 1'b1;
		cyc(400);
		t_static();
		t_dynamic();
		t_retain();
		summarize();
	end
	initial
	begin
		#2000000;
		fails++;
		summarize();
	end
endmodule
bind eer_router eer_router_assertions #(.N_IN(N_IN), .HPD_CYC(HPD_CYC)) chk_u (
	.ref_clk     (ref_clk),
	.rstn        (rstn),
	.snk_done    (snk_done),
	.snk_valid   (snk_valid),
	.cfg_we      (cfg_we),
	.cfg_in      (cfg_in),
	.cfg_mode    (cfg_mode),
	.ddc_addr    (ddc_addr),
	.ddc_data    (ddc_data),
	.ddc_has_ext (ddc_has_ext),
	.hpd         (hpd),
	.copy_busy   (copy_busy)
);
